// ### hdl/rack_fault_pkg.sv
// constants and carrier types for the rack fault-status latch block
// assumes a single 10 MHz system clock and synchronous level inputs
package rack_fault_pkg;

  // system clock
  localparam int CLK_HZ = 10_000_000;

  // cpu silence before the cpu-alive lamp drops, in milliseconds
  localparam int WATCHDOG_TIME_MS = 1000;
  localparam int WATCHDOG_CYCLES_DEF = WATCHDOG_TIME_MS * (CLK_HZ / 1000);

  // parity error age at which it counts as persistent, in milliseconds
  localparam int PARITY_HALT_TIME_MS = 10;
  localparam int PARITY_HALT_CYCLES_DEF =
    PARITY_HALT_TIME_MS * (CLK_HZ / 1000);

  // number of racks below this one on the chain
  localparam int DS_RACKS_DEF = 9;

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OUT_BYTE_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] LAMP_STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] FAULT_NOW_OFS = 4'h8;

  // output byte
  localparam int OUT_BYTE_W = 8;
  localparam logic [OUT_BYTE_W-1:0] OUT_BYTE_RST = 8'h00;
  localparam int OUT_BYTE_LAMP_RESET_BIT = 2;

  // lamp status word, bit positions
  localparam int LAMP_SUMMARY_BIT = 4;
  localparam int LAMP_LINK_BIT = 3;
  localparam int LAMP_RACK_BIT = 2;
  localparam int LAMP_PARITY_BIT = 1;
  localparam int LAMP_ALIVE_BIT = 0;

  // fault-now word, bit positions
  localparam int NOW_DS_BIT = 0;
  localparam int NOW_RACK_BIT = 1;
  localparam int NOW_PARITY_BIT = 2;
  localparam int NOW_PERSIST_BIT = 3;
  localparam int NOW_SILENT_BIT = 4;

  // lamps, high means healthy
  typedef struct packed {
    logic summary_healthy_lamp;
    logic downstream_link_healthy_lamp;
    logic rack_power_healthy_lamp;
    logic input_parity_healthy_lamp;
    logic cpu_alive_lamp;
  } lamps_t;

  localparam lamps_t LAMPS_RST = 5'h1F;

  // live fault levels from the rack hardware
  typedef struct packed {
    logic downstream_fault;
    logic rack_fault;
    logic local_parity_err;
  } faults_t;

  // answers toward the cpu side of the chain
  typedef struct packed {
    logic chain_healthy;
    logic cpu_halt_req;
  } chain_status_t;

  localparam chain_status_t CHAIN_RST = 2'h2;

endpackage

// ### hdl/rack_fault_status_latches.sv
// fault-status latches of an i/o chain receiver: lamps, cpu answers
// assumes synchronous inputs, a pulse per cpu access on cpu_comm
`timescale 1ns/100ps

module rack_fault_status_latches
  import rack_fault_pkg::*;
#(
  parameter int WATCHDOG_CYCLES = WATCHDOG_CYCLES_DEF,
  parameter int PARITY_HALT_CYCLES = PARITY_HALT_CYCLES_DEF,
  parameter int DS_RACKS = DS_RACKS_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire faults_t faults,
  input wire logic [DS_RACKS-1:0] ds_parity_err,
  input wire logic [DS_RACKS-1:0] ds_switch6_closed,
  input wire logic switch6_closed,
  input wire logic switch7_closed,
  input wire logic reset_button,
  input wire logic cpu_comm,
  output lamps_t lamps,
  output chain_status_t chain_status,
  output logic [OUT_BYTE_W-1:0] out_byte
);

  localparam int WD_W = $clog2(WATCHDOG_CYCLES + 1);
  localparam int PH_W = $clog2(PARITY_HALT_CYCLES + 1);
  localparam logic [WD_W-1:0] WD_LAST = WD_W'(WATCHDOG_CYCLES);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(PARITY_HALT_CYCLES);

  lamps_t lamps_reg, lamps_next;
  chain_status_t chain_reg, chain_next;
  logic [OUT_BYTE_W-1:0] out_byte_reg, out_byte_next;
  logic bit2_prev_reg, bit2_prev_next;
  logic [WD_W-1:0] wd_cnt_reg, wd_cnt_next;
  logic [PH_W-1:0] ph_cnt_reg, ph_cnt_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [DS_RACKS-1:0] ds_par_gated;
  logic parity_now;
  logic parity_persist;
  logic cpu_silent;
  logic lamp_reset;

  // per-rack gate on downstream parity by that rack's own switch 6
  genvar gi;
  generate
    for (gi = 0; gi < DS_RACKS; gi++) begin : g_ds_par
      assign ds_par_gated[gi] = ds_parity_err[gi] & ds_switch6_closed[gi];
    end
  endgenerate

  assign parity_now = (switch6_closed & faults.local_parity_err)
    | (switch7_closed & (|ds_par_gated));
  // persistent only while the gated error is still present
  assign parity_persist = parity_now && (ph_cnt_reg == PH_LAST);
  assign cpu_silent = (wd_cnt_reg == WD_LAST);
  // lamp reset on button or on the fall of output byte bit 2
  assign lamp_reset = reset_button
    | (bit2_prev_reg & ~out_byte_reg[OUT_BYTE_LAMP_RESET_BIT]);

  // register port and output byte
  always_comb begin
    out_byte_next = out_byte_reg;
    bit2_prev_next = out_byte_reg[OUT_BYTE_LAMP_RESET_BIT];
    rdata_next = '0;
    if (reg_wr && reg_addr == OUT_BYTE_OFS) begin
      out_byte_next = reg_wdata[OUT_BYTE_W-1:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        OUT_BYTE_OFS: rdata_next = {{(DATA_W-OUT_BYTE_W){1'b0}},
                                    out_byte_reg};
        LAMP_STATUS_OFS: rdata_next = {{(DATA_W-5){1'b0}}, lamps_reg};
        FAULT_NOW_OFS: begin
          rdata_next[NOW_DS_BIT] = faults.downstream_fault;
          rdata_next[NOW_RACK_BIT] = faults.rack_fault;
          rdata_next[NOW_PARITY_BIT] = parity_now;
          rdata_next[NOW_PERSIST_BIT] = parity_persist;
          rdata_next[NOW_SILENT_BIT] = cpu_silent;
        end
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_byte_reg <= OUT_BYTE_RST;
      bit2_prev_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      out_byte_reg <= out_byte_next;
      bit2_prev_reg <= bit2_prev_next;
      rdata_reg <= rdata_next;
    end
  end

  // timers: cpu silence and parity error age
  always_comb begin
    wd_cnt_next = wd_cnt_reg;
    ph_cnt_next = ph_cnt_reg;
    if (cpu_comm || lamp_reset) begin
      wd_cnt_next = '0;
    end else if (!cpu_silent) begin
      wd_cnt_next = wd_cnt_reg + WD_W'(1);
    end
    if (!parity_now) begin
      ph_cnt_next = '0;
    end else if (!parity_persist) begin
      ph_cnt_next = ph_cnt_reg + PH_W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wd_cnt_reg <= '0;
      ph_cnt_reg <= '0;
    end else begin
      wd_cnt_reg <= wd_cnt_next;
      ph_cnt_reg <= ph_cnt_next;
    end
  end

  // lamps and chain answers; a live fault wins over a reset
  always_comb begin
    lamps_next = lamp_reset ? LAMPS_RST : lamps_reg;
    lamps_next.summary_healthy_lamp =
      ~(faults.downstream_fault | faults.rack_fault);
    if (faults.downstream_fault) begin
      lamps_next.downstream_link_healthy_lamp = 1'b0;
    end
    if (faults.rack_fault) begin
      lamps_next.rack_power_healthy_lamp = 1'b0;
    end
    if (parity_now) begin
      lamps_next.input_parity_healthy_lamp = 1'b0;
    end
    if (parity_persist || cpu_silent) begin
      lamps_next.cpu_alive_lamp = 1'b0;
    end
    chain_next.chain_healthy =
      ~(faults.downstream_fault | faults.rack_fault);
    chain_next.cpu_halt_req = faults.downstream_fault
      | faults.rack_fault | parity_persist;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lamps_reg <= LAMPS_RST;
      chain_reg <= CHAIN_RST;
    end else begin
      lamps_reg <= lamps_next;
      chain_reg <= chain_next;
    end
  end

  assign lamps = lamps_reg;
  assign chain_status = chain_reg;
  assign out_byte = out_byte_reg;
  assign reg_rdata = rdata_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_link_latch;
    faults.downstream_fault ##1 (!faults.downstream_fault && !lamp_reset)
      |=> !lamps_reg.downstream_link_healthy_lamp;
  endproperty
  a_link_latch: assert property (p_link_latch)
    else $error("downstream link lamp did not stay latched");

  property p_ds_now;
    faults.downstream_fault |=> !lamps_reg.summary_healthy_lamp
      && !lamps_reg.downstream_link_healthy_lamp
      && !chain_reg.chain_healthy && chain_reg.cpu_halt_req;
  endproperty
  a_ds_now: assert property (p_ds_now)
    else $error("live downstream fault not shown");

  property p_bit2_reset;
    $fell(out_byte_reg[OUT_BYTE_LAMP_RESET_BIT]) && !faults.rack_fault
      |=> lamps_reg.rack_power_healthy_lamp;
  endproperty
  a_bit2_reset: assert property (p_bit2_reset)
    else $error("output byte bit 2 pulse did not reset lamps");

  property p_rack_latch;
    !lamps_reg.rack_power_healthy_lamp && !lamp_reset && !faults.rack_fault
      && !faults.downstream_fault
      |=> !lamps_reg.rack_power_healthy_lamp
      && lamps_reg.summary_healthy_lamp;
  endproperty
  a_rack_latch: assert property (p_rack_latch)
    else $error("rack power lamp latch or summary wrong");

  property p_rack_now;
    faults.rack_fault |=> !lamps_reg.summary_healthy_lamp
      && !lamps_reg.rack_power_healthy_lamp && !chain_reg.chain_healthy;
  endproperty
  a_rack_now: assert property (p_rack_now)
    else $error("live rack fault not shown");

  property p_par_gate;
    lamps_reg.input_parity_healthy_lamp && !switch7_closed
      && !switch6_closed |=> lamps_reg.input_parity_healthy_lamp;
  endproperty
  a_par_gate: assert property (p_par_gate)
    else $error("parity seen with switches open");

  property p_par_brief;
    parity_now && !parity_persist && !cpu_silent
      && lamps_reg.cpu_alive_lamp
      |=> !lamps_reg.input_parity_healthy_lamp && lamps_reg.cpu_alive_lamp;
  endproperty
  a_par_brief: assert property (p_par_brief)
    else $error("brief parity error handled wrongly");

  property p_par_persist;
    parity_persist |=> !lamps_reg.cpu_alive_lamp
      && !lamps_reg.input_parity_healthy_lamp && chain_reg.cpu_halt_req;
  endproperty
  a_par_persist: assert property (p_par_persist)
    else $error("persistent parity did not halt");

  property p_button;
    reset_button && !faults.downstream_fault && !parity_now
      && !cpu_silent |=> lamps_reg.downstream_link_healthy_lamp
      && lamps_reg.input_parity_healthy_lamp && lamps_reg.cpu_alive_lamp;
  endproperty
  a_button: assert property (p_button)
    else $error("button did not reset lamps");

  property p_own_par;
    switch6_closed && faults.local_parity_err
      |=> !lamps_reg.input_parity_healthy_lamp;
  endproperty
  a_own_par: assert property (p_own_par)
    else $error("own rack parity error missed");

  property p_silent;
    cpu_silent |=> !lamps_reg.cpu_alive_lamp;
  endproperty
  a_silent: assert property (p_silent)
    else $error("cpu silence did not drop alive lamp");

  property p_reset_live;
    lamp_reset && faults.downstream_fault
      |=> !lamps_reg.downstream_link_healthy_lamp;
  endproperty
  a_reset_live: assert property (p_reset_live)
    else $error("live fault hidden by reset");

  property p_chain_follow;
    !faults.downstream_fault && !faults.rack_fault
      |=> chain_reg.chain_healthy && lamps_reg.summary_healthy_lamp;
  endproperty
  a_chain_follow: assert property (p_chain_follow)
    else $error("summary or chain healthy not restored");

  property p_ds_gate;
    !switch7_closed && !(switch6_closed && faults.local_parity_err)
      && lamps_reg.input_parity_healthy_lamp
      |=> lamps_reg.input_parity_healthy_lamp;
  endproperty
  a_ds_gate: assert property (p_ds_gate)
    else $error("downstream parity seen with switch 7 open");

  property p_alive_hold;
    lamps_reg.cpu_alive_lamp && !parity_persist && !cpu_silent
      |=> lamps_reg.cpu_alive_lamp;
  endproperty
  a_alive_hold: assert property (p_alive_hold)
    else $error("cpu alive lamp dropped without cause");

  property p_no_halt;
    !faults.downstream_fault && !faults.rack_fault && !parity_persist
      |=> !chain_reg.cpu_halt_req;
  endproperty
  a_no_halt: assert property (p_no_halt)
    else $error("cpu halt requested without cause");

endmodule

// ### verif/cpu_chain_model.sv
// cpu side of the i/o chain: scans, halts on request, logs parity address
// assumes chain_status from the receiver block on the same system clock
`timescale 1ns/100ps

module cpu_chain_model
  import rack_fault_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire chain_status_t chain_status,
  input wire logic talk_en,
  input wire logic [7:0] bad_addr,
  output logic cpu_comm,
  output logic running,
  output logic [23:0] fault_flags
);
  logic [1:0] scan_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scan_reg <= 2'h0;
      cpu_comm <= 1'b0;
      running <= 1'b1;
      fault_flags <= 24'h000000;
    end else begin
      scan_reg <= scan_reg + 2'h1;
      // a halted cpu stops scanning the chain
      running <= !chain_status.cpu_halt_req;
      cpu_comm <= talk_en && running && (scan_reg == 2'h3);
      // halt with the chain still healthy can only be parity
      if (chain_status.cpu_halt_req && chain_status.chain_healthy) begin
        fault_flags[15:8] <= bad_addr;
      end
    end
  end
endmodule

// ### verif/tb_top.sv
// self-checking bench for the rack fault-status latch block
// assumes the cpu chain model as partner and shortened timer parameters
`timescale 1ns/100ps

module tb_top
  import rack_fault_pkg::*;
;
  localparam int WD = 20;
  localparam int PH = 8;
  localparam int NR = 3;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  faults_t faults = '0;
  logic [NR-1:0] ds_parity_err = '0;
  logic [NR-1:0] ds_switch6_closed = '0;
  logic switch6_closed = 1'b0;
  logic switch7_closed = 1'b0;
  logic reset_button = 1'b0;
  logic talk_en = 1'b1;
  logic [7:0] bad_addr = 8'h00;
  logic cpu_comm;
  logic running;
  logic [23:0] fault_flags;
  lamps_t lamps;
  chain_status_t chain_status;
  logic [OUT_BYTE_W-1:0] out_byte;
  int fail_count = 0;
  int comparisons = 0;
  int seed = 32'h76cb;

  always #50 clk_sys = ~clk_sys;

  rack_fault_status_latches #(.WATCHDOG_CYCLES(WD),
    .PARITY_HALT_CYCLES(PH), .DS_RACKS(NR)) dut (.clk_sys(clk_sys),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .faults(faults), .ds_parity_err(ds_parity_err),
    .ds_switch6_closed(ds_switch6_closed),
    .switch6_closed(switch6_closed), .switch7_closed(switch7_closed),
    .reset_button(reset_button), .cpu_comm(cpu_comm), .lamps(lamps),
    .chain_status(chain_status), .out_byte(out_byte));

  cpu_chain_model cpu (.clk_sys(clk_sys), .rst(rst),
    .chain_status(chain_status), .talk_en(talk_en), .bad_addr(bad_addr),
    .cpu_comm(cpu_comm), .running(running), .fault_flags(fault_flags));

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic btn();
    @(posedge clk_sys);
    reset_button <= 1'b1;
    @(posedge clk_sys);
    reset_button <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic ticks(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic par_ok(logic s6, logic s7, logic [NR-1:0] d6,
    logic [NR-1:0] de, logic le);
    return !((le && s6) || ((|(de & d6)) && s7));
  endfunction

  initial begin
    #3_000_000;
    fail_count++;
    summarize();
  end

  initial begin
    logic [DATA_W-1:0] d;
    logic [31:0] r;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    ticks(1);
    chk("lamps_rst", lamps, LAMPS_RST);
    chk("chain_rst", chain_status, CHAIN_RST);
    wr(LAMP_STATUS_OFS, 32'h0);
    rd(LAMP_STATUS_OFS, d);
    chk("lamp_reg", d, 32'h1F);
    rd(4'hC, d);
    chk("unmapped", d, 32'h0);
    @(posedge clk_sys);
    faults.downstream_fault <= 1'b1;
    @(posedge clk_sys);
    faults.downstream_fault <= 1'b0;
    #1 chk("ds_live", {lamps, chain_status}, 7'h1D);
    ticks(1);
    chk("ds_latch", {lamps, chain_status}, 7'h5E);
    wr(OUT_BYTE_OFS, 32'h4);
    chk("out_byte", out_byte, 8'h04);
    rd(OUT_BYTE_OFS, d);
    chk("out_rd", d, 32'h4);
    wr(OUT_BYTE_OFS, 32'h0);
    ticks(2);
    chk("sw_reset", lamps, 5'h1F);
    @(posedge clk_sys);
    faults.rack_fault <= 1'b1;
    ticks(2);
    chk("rack_live", {lamps, chain_status}, 7'h2D);
    rd(FAULT_NOW_OFS, d);
    chk("now_rack", d, 32'h2);
    btn();
    chk("rack_held", lamps, 5'h0B);
    @(posedge clk_sys);
    faults.rack_fault <= 1'b0;
    ticks(1);
    chk("rack_latch", lamps, 5'h1B);
    btn();
    chk("btn_reset", lamps, 5'h1F);
    @(posedge clk_sys);
    faults.downstream_fault <= 1'b1;
    btn();
    chk("ds_held", lamps, 5'h07);
    @(posedge clk_sys);
    faults.downstream_fault <= 1'b0;
    ticks(1);
    chk("ds_after", lamps, 5'h17);
    btn();
    chk("ds_cleared", lamps, 5'h1F);
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      if (i == 0)
        r[5:0] = 6'h23;
      if (i == 1)
        r[8:0] = 9'h12E;
      if (i == 2)
        r[8:0] = 9'h0AE;
      @(posedge clk_sys);
      switch6_closed <= r[0];
      switch7_closed <= r[1];
      ds_switch6_closed <= r[4:2];
      faults.local_parity_err <= r[5];
      ds_parity_err <= r[8:6];
      repeat (3) @(posedge clk_sys);
      faults.local_parity_err <= 1'b0;
      ds_parity_err <= '0;
      ticks(2);
      chk("par_lamp", lamps.input_parity_healthy_lamp,
        par_ok(r[0], r[1], r[4:2], r[8:6], r[5]));
      chk("par_alive", lamps.cpu_alive_lamp, 1'b1);
      btn();
    end
    @(posedge clk_sys);
    switch6_closed <= 1'b1;
    faults.local_parity_err <= 1'b1;
    bad_addr <= 8'h5A;
    ticks(PH + 4);
    chk("par_persist", {lamps, chain_status}, 7'h73);
    chk("flag_addr", fault_flags[15:8], 8'h5A);
    rd(FAULT_NOW_OFS, d);
    chk("now_persist", d, 32'hC);
    @(posedge clk_sys);
    faults.local_parity_err <= 1'b0;
    ticks(2);
    btn();
    chk("par_clear", lamps, 5'h1F);
    ticks(3 * WD);
    chk("wd_talking", lamps.cpu_alive_lamp, 1'b1);
    @(posedge clk_sys);
    talk_en <= 1'b0;
    ticks(WD - 6);
    chk("wd_early", lamps.cpu_alive_lamp, 1'b1);
    ticks(10);
    chk("wd_silent", lamps.cpu_alive_lamp, 1'b0);
    summarize();
  end
endmodule
